// [logic/lspe_engine.v]
// LED string PWM engine with APB register slave
`timescale 1ns/1ns
`include "lspe_map.vh"
module lspe_engine (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        frame_sync_input,
    input  wire        line_clock_input,
    input  wire        ext_pulse_input,
    output reg  [15:0] string_sink_outputs
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function in_table;
        input [7:0] addr;
        input [7:0] base;
        begin
            in_table = (addr >= base) && (addr < base + `LSPE_TABLE_SPAN)
                       && (addr[1:0] == 2'b00);
        end
    endfunction

    function rising;
        input now;
        input last;
        begin
            rising = now & ~last;
        end
    endfunction

    // Count of cycles including the current one, held at full scale
    function [11:0] sat_inc;
        input [11:0] v;
        begin
            sat_inc = (v == `LSPE_COUNT_MAX) ? v : v + 12'h001;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [`LSPE_CTRL_WIDTH-1:0] ctrl;
    reg  [15:0]                 str_enable;
    reg  [7:0]                  intensity;
    reg  [11:0]                 frame_len;
    reg  [7:0]                  line_div;

    wire ext_sync  = ctrl[`LSPE_CTRL_EXT_SYNC];
    wire ext_line  = ctrl[`LSPE_CTRL_EXT_LINE];
    wire scale_en  = ctrl[`LSPE_CTRL_SCALE_EN];
    wire spread_en = ctrl[`LSPE_CTRL_SPREAD_EN];
    wire gate_en   = ctrl[`LSPE_CTRL_GATE_EN];
    wire direct    = ctrl[`LSPE_CTRL_EXT_IN_EN] & ctrl[`LSPE_CTRL_DIRECT];

    wire access    = psel & penable;
    wire on_hit    = in_table(paddr, `LSPE_ONTIME_BASE);
    wire ph_hit    = in_table(paddr, `LSPE_PHASE_BASE);
    wire reg_hit   = (paddr == `LSPE_CTRL_OFS) || (paddr == `LSPE_ENABLE_OFS)
                     || (paddr == `LSPE_INTENSITY_OFS) || (paddr == `LSPE_FRAME_LEN_OFS)
                     || (paddr == `LSPE_LINE_DIV_OFS) || (paddr == `LSPE_STATUS_OFS);
    wire mapped    = on_hit | ph_hit | reg_hit;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= `LSPE_CTRL_RST;
            str_enable <= `LSPE_ENABLE_RST;
            intensity  <= `LSPE_INTENSITY_RST;
            frame_len  <= `LSPE_FRAME_LEN_RST;
            line_div   <= `LSPE_LINE_DIV_RST;
        end else if (access && pwrite) begin
            if (paddr == `LSPE_CTRL_OFS) begin
                ctrl <= pwdata[`LSPE_CTRL_WIDTH-1:0];
            end else if (paddr == `LSPE_ENABLE_OFS) begin
                str_enable <= pwdata[15:0];
            end else if (paddr == `LSPE_INTENSITY_OFS) begin
                intensity <= pwdata[7:0];
            end else if (paddr == `LSPE_FRAME_LEN_OFS) begin
                frame_len <= pwdata[11:0];
            end else if (paddr == `LSPE_LINE_DIV_OFS) begin
                line_div <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // String table
    // ------------------------------------------------------------------------
    reg  [3:0]  scan_idx;
    reg  [3:0]  scan_idx_d;
    wire [23:0] mem_rd_a;
    wire [23:0] mem_rd_b;

    lspe_mem u_mem (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_lo     (access & pwrite & on_hit),
        .wr_hi     (access & pwrite & ph_hit),
        .wr_addr   (paddr[5:2]),
        .wr_data   (pwdata[11:0]),
        .rd_addr_a (paddr[5:2]),
        .rd_data_a (mem_rd_a),
        .rd_addr_b (scan_idx),
        .rd_data_b (mem_rd_b)
    );

    // ------------------------------------------------------------------------
    // Line clock and frame timebase
    // ------------------------------------------------------------------------
    reg  [7:0]  div_cnt;
    reg         line_last;
    reg         sync_last;
    reg  [11:0] frame_pos;
    reg  [11:0] frame_meas;

    wire int_line   = (div_cnt == line_div);
    wire line_tick  = ext_line ? rising(line_clock_input, line_last) : int_line;
    wire int_end    = line_tick && (frame_pos >= frame_len - 12'h001);
    wire frame_start = ext_sync ? rising(frame_sync_input, sync_last) : int_end;
    wire [11:0] frame_period = ext_sync ? frame_meas : frame_len;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt    <= 8'h00;
            line_last  <= 1'b0;
            sync_last  <= 1'b0;
            frame_pos  <= 12'h000;
            frame_meas <= `LSPE_FRAME_LEN_RST;
        end else begin
            div_cnt   <= int_line ? 8'h00 : div_cnt + 8'h01;
            line_last <= line_clock_input;
            sync_last <= frame_sync_input;
            if (frame_start) begin
                frame_pos <= 12'h000;
                if (frame_pos != 12'h000) begin
                    frame_meas <= frame_pos + {11'h000, line_tick};
                end
            end else if (line_tick && frame_pos != `LSPE_COUNT_MAX) begin
                frame_pos <= frame_pos + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // External pulse timebase for direct drive with spreading
    // ------------------------------------------------------------------------
    reg         ext_last;
    reg  [11:0] ext_pos;
    reg  [11:0] ext_period;
    reg  [11:0] ext_high;

    wire ext_rise = rising(ext_pulse_input, ext_last);
    wire ext_fall = ext_last & ~ext_pulse_input;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_last   <= 1'b0;
            ext_pos    <= 12'h000;
            ext_period <= 12'h000;
            ext_high   <= 12'h000;
        end else begin
            ext_last <= ext_pulse_input;
            if (ext_rise) begin
                ext_pos    <= 12'h000;
                ext_period <= sat_inc(ext_pos);
            end else if (ext_pos != `LSPE_COUNT_MAX) begin
                ext_pos <= ext_pos + 12'h001;
            end
            if (ext_fall) begin
                ext_high <= sat_inc(ext_pos);
            end
        end
    end

    // ------------------------------------------------------------------------
    // String scanner: one string evaluated per pclk cycle
    // ------------------------------------------------------------------------
    wire [11:0] cur_pos    = direct ? ext_pos : frame_pos;
    wire [11:0] cur_period = direct ? ext_period : frame_period;
    wire [19:0] scaled     = mem_rd_b[11:0] * ({1'b0, intensity} + 9'h001);
    wire [11:0] base_on    = scale_en ? scaled[19:8] : mem_rd_b[11:0];
    wire [11:0] cur_on     = direct ? ext_high : base_on;
    wire [15:0] spread_mul = cur_period * scan_idx_d;
    wire [11:0] spread_off = (spread_en || direct) ? spread_mul[15:4] : 12'h000;
    wire [11:0] cur_delay  = direct ? spread_off : mem_rd_b[23:12] + spread_off;
    wire [11:0] rel_pos    = (cur_pos >= cur_delay) ? cur_pos - cur_delay
                                                    : cur_pos + cur_period - cur_delay;
    // Full range reachable only when the frame holds enough lines
    wire        cur_out    = str_enable[scan_idx_d] && (cur_on != 12'h000)
                             && ((cur_on >= cur_period) || (rel_pos < cur_on));

    reg  [15:0] eng_out;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_idx   <= 4'h0;
            scan_idx_d <= 4'h0;
            eng_out    <= 16'h0000;
        end else begin
            scan_idx   <= scan_idx + 4'h1;
            scan_idx_d <= scan_idx;
            eng_out[scan_idx_d] <= cur_out;
        end
    end

    // ------------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------------
    reg [15:0] next_strings;

    always @* begin
        if (direct && !spread_en) begin
            next_strings = {16{ext_pulse_input}} & str_enable;
        end else if (direct) begin
            next_strings = eng_out;
        end else if (gate_en) begin
            next_strings = eng_out & {16{ext_pulse_input}};
        end else begin
            next_strings = eng_out;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            string_sink_outputs <= 16'h0000;
        end else begin
            string_sink_outputs <= next_strings;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @* begin
        prdata = 32'h00000000;
        if (on_hit) begin
            prdata = {20'h00000, mem_rd_a[11:0]};
        end else if (ph_hit) begin
            prdata = {20'h00000, mem_rd_a[23:12]};
        end else if (paddr == `LSPE_CTRL_OFS) begin
            prdata = {25'h0000000, ctrl};
        end else if (paddr == `LSPE_ENABLE_OFS) begin
            prdata = {16'h0000, str_enable};
        end else if (paddr == `LSPE_INTENSITY_OFS) begin
            prdata = {24'h000000, intensity};
        end else if (paddr == `LSPE_FRAME_LEN_OFS) begin
            prdata = {20'h00000, frame_len};
        end else if (paddr == `LSPE_LINE_DIV_OFS) begin
            prdata = {24'h000000, line_div};
        end else if (paddr == `LSPE_STATUS_OFS) begin
            prdata = {4'h0, frame_pos, string_sink_outputs};
        end
    end

endmodule // lspe_engine

// [logic/lspe_map.vh]
// Offsets, fields, reset values and timing constants of the string PWM engine
//
// Functional notes
// - Frame rate from frame sync or oscillator
// - Per-string 12-bit on time in lines
// - Optional 8-bit global intensity scales on time
// - Resolution limited by lines per frame
// - Line clock external or internally generated
// - Per-string phase delay in line clocks
// - Spreading delays string n by n/16 frame
// - Direct mode: external pulse sets duty, frequency
// - Spreading still available in direct mode
// - Direct needs input enable and direct select
// - Gate enable gates engine with external pulse
`ifndef LSPE_MAP_VH
`define LSPE_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LSPE_CTRL_OFS         8'h00
`define LSPE_ENABLE_OFS       8'h04
`define LSPE_INTENSITY_OFS    8'h08
`define LSPE_FRAME_LEN_OFS    8'h0c
`define LSPE_LINE_DIV_OFS     8'h10
`define LSPE_STATUS_OFS       8'h14
`define LSPE_ONTIME_BASE      8'h40
`define LSPE_PHASE_BASE       8'h80
`define LSPE_TABLE_SPAN       8'h40

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define LSPE_CTRL_EXT_SYNC    0
`define LSPE_CTRL_EXT_LINE    1
`define LSPE_CTRL_SCALE_EN    2
`define LSPE_CTRL_SPREAD_EN   3
`define LSPE_CTRL_EXT_IN_EN   4
`define LSPE_CTRL_DIRECT      5
`define LSPE_CTRL_GATE_EN     6
`define LSPE_CTRL_WIDTH       7

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define LSPE_CTRL_RST         7'h00
`define LSPE_ENABLE_RST       16'h0000
`define LSPE_INTENSITY_RST    8'hff
`define LSPE_FRAME_LEN_RST    12'h400
`define LSPE_LINE_DIV_RST     8'h27
`define LSPE_COUNT_MAX        12'hfff
`define LSPE_STRINGS          16

`endif

// [logic/lspe_mem.v]
// Per-string on-time and phase table with two registered read ports
`timescale 1ns/1ns
module lspe_mem (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        wr_lo,
    input  wire        wr_hi,
    input  wire [3:0]  wr_addr,
    input  wire [11:0] wr_data,
    input  wire [3:0]  rd_addr_a,
    output reg  [23:0] rd_data_a,
    input  wire [3:0]  rd_addr_b,
    output reg  [23:0] rd_data_b
);

    reg [23:0] table_q [0:15];
    integer    i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 16; i = i + 1) begin
                table_q[i] <= 24'h000000;
            end
            rd_data_a <= 24'h000000;
            rd_data_b <= 24'h000000;
        end else begin
            if (wr_lo) begin
                table_q[wr_addr][11:0] <= wr_data;
            end
            if (wr_hi) begin
                table_q[wr_addr][23:12] <= wr_data;
            end
            rd_data_a <= table_q[rd_addr_a];
            rd_data_b <= table_q[rd_addr_b];
        end
    end

endmodule // lspe_mem

// [sim/lspe_engine_properties.sv]
// Port checker of the string PWM engine
`timescale 1ns/1ns
module lspe_engine_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        frame_sync_input,
    input wire logic        line_clock_input,
    input wire logic        ext_pulse_input,
    input wire logic [15:0] string_sink_outputs
);
    // ------------------------------------------------------------
    // Shadow of control and enable, settle counters
    // ------------------------------------------------------------
    logic [6:0]  ctrl_sh;
    logic [15:0] en_sh;
    logic [5:0]  quiet;
    logic [4:0]  low_n;
    wire         wr = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_sh <= 7'h00;
            en_sh <= 16'h0000;
            quiet <= 6'h00;
            low_n <= 5'h00;
        end else begin
            if (wr && paddr == 8'h00) ctrl_sh <= pwdata[6:0];
            if (wr && paddr == 8'h04) en_sh <= pwdata[15:0];
            quiet <= (psel && pwrite && paddr < 8'h08) ? 6'h00 : quiet + {5'h0, quiet != 6'h28};
            low_n <= ext_pulse_input ? 5'h00 : low_n + {4'h0, low_n != 5'h18};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc;
        psel && penable;
    endsequence
    sequence rd_at(logic [7:0] a);
        acc ##0 (!pwrite && paddr == a);
    endsequence
    wire bad = paddr[1:0] != 2'b00 || (paddr > 8'h14 && paddr < 8'h40) || paddr > 8'hbc;
    AST_READY: assert property (acc |-> pready)
        else $error("pready low in access phase");
    AST_UNMAPPED: assert property (acc ##0 bad |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (acc ##0 !bad |-> !pslverr)
        else $error("mapped access refused");
    AST_CTRL_RB: assert property (rd_at(8'h00) |-> prdata == {25'h0, ctrl_sh})
        else $error("control readback wrong");
    AST_EN_RB: assert property (rd_at(8'h04) |-> prdata == {16'h0, en_sh})
        else $error("enable readback wrong");
    AST_DISABLED: assert property (quiet == 6'h28 |-> (string_sink_outputs & ~en_sh) == 16'h0)
        else $error("disabled string driven");
    AST_DIRECT: assert property (quiet == 6'h28 && ctrl_sh[5:3] == 3'b110
        |-> string_sink_outputs == ({16{$past(ext_pulse_input)}} & en_sh))
        else $error("direct drive not passed through");
    AST_GATE: assert property (quiet == 6'h28 && ctrl_sh[6] && ctrl_sh[5:4] != 2'b11
        && low_n == 5'h18 |-> string_sink_outputs == 16'h0)
        else $error("gate closed but strings driven");
endmodule // lspe_engine_properties

bind lspe_engine lspe_engine_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync_input(frame_sync_input), .line_clock_input(line_clock_input),
    .ext_pulse_input(ext_pulse_input), .string_sink_outputs(string_sink_outputs));

// [sim/lspe_engine_tb.sv]
// Self-checking bench of the string PWM engine
`timescale 1ns/1ns
module lspe_engine_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        ext = 0, run = 0, err, pready, pslverr, fsync, lclk;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic [15:0] outs, en;
    logic        q[60];
    int          num_errors = 0, n_checks = 0, on[16], ph[16], inten, ctl, per = 12, lpos;
    int          tbl[5] = '{32'h03, 32'h07, 32'h0b, 32'h43, 32'h23};
    int          rst_exp[5] = '{32'h0, 32'h0, 32'hff, 32'h400, 32'h27};
    lspe_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_sync_input(fsync), .line_clock_input(lclk),
        .ext_pulse_input(ext), .string_sink_outputs(outs));
    lspe_video_src src (.pclk(pclk), .run(run), .line_len(8'h28), .lines(8'h0d),
        .frame_sync(fsync), .line_clk(lclk));
    initial forever #50 pclk = ~pclk;
    // ------------------------------------------------------------
    // Bus cycles, comparison, model
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic exp_on(int n, int pos);
        int o = ctl[2] ? (on[n] * (inten + 1)) >> 8 : on[n];
        int s = (ph[n] + (ctl[3] ? per * n / 16 : 0)) % per;
        if (!en[n] || o == 0) return 1'b0;
        if (o >= per) return 1'b1;
        return ((pos - s + per) % per) < o;
    endfunction
    task automatic tally_and_finish;
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h0dc8856c));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd, rst_exp[i], "reset value");
        end
        apb(1'b0, 8'h3c, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped");
        $display("Test registers done");
        run <= 1'b1;
        foreach (tbl[p]) begin
            ctl = tbl[p];
            inten = $urandom_range(255);
            en = 16'($urandom);
            for (int n = 0; n < 16; n++) begin
                on[n] = (n < 2) ? 12 * n : $urandom_range(6);
                ph[n] = $urandom_range(5);
                apb(1'b1, 8'h40 + 8'(4 * n), on[n]);
                apb(1'b1, 8'h80 + 8'(4 * n), ph[n]);
            end
            apb(1'b1, 8'h08, inten);
            apb(1'b1, 8'h04, {16'h0, en});
            apb(1'b1, 8'h00, ctl);
            for (int f = 0; f < 2; f++) begin
                @(posedge fsync);
                for (int l = 0; l < 12; l++) begin
                    ext <= 1'($urandom);
                    repeat (30) @(posedge pclk);
                    @(negedge pclk);
                    for (int n = 0; n < 16 && f == 1; n++)
                        check(outs[n], exp_on(n, l) & (!ctl[6] | ext), "string");
                    repeat (10) @(posedge pclk);
                end
            end
            $display("Test engine pass %0d done", p);
        end
        ctl = 32'h30;
        apb(1'b1, 8'h00, ctl);
        for (int c = 0; c < 60; c++) begin
            @(posedge pclk);
            q[c] = 1'($urandom);
            ext <= q[c];
            @(negedge pclk);
            if (c > 0) check(outs, en & {16{q[c - 1]}}, "direct");
        end
        $display("Test direct done");
        // Direct drive with spreading: 320-cycle external period, half duty
        ctl = 32'h38;
        apb(1'b1, 8'h00, ctl);
        for (int c = 0; c < 1280; c++) begin
            @(posedge pclk);
            ext <= (c % 320) < 160;
            @(negedge pclk);
            for (int n = 0; n < 16 && c >= 680; n++) begin
                lpos = (c % 320 - 20 * n + 320) % 320;
                if (lpos % 160 > 24 && lpos % 160 < 156)
                    check(outs[n], en[n] & (lpos < 160), "spread direct");
            end
        end
        $display("Test spread direct done");
        // Internal frame of 12 lines, internal line divider
        ctl = 32'h0;
        apb(1'b1, 8'h0c, 32'h0c);
        apb(1'b1, 8'h00, ctl);
        apb(1'b0, 8'h14, 32'h0);
        for (int k = 0; k < 28; k++) begin
            lpos = rd[27:16];
            do apb(1'b0, 8'h14, 32'h0); while (rd[27:16] == lpos);
            if (k > 0) check(rd[27:16], (lpos + 1) % per, "frame position");
            repeat (25) @(posedge pclk);
            @(negedge pclk);
            for (int n = 0; n < 16; n++)
                check(outs[n], exp_on(n, rd[27:16]), "internal string");
        end
        $display("Test internal timebase done");
        tally_and_finish;
    end
endmodule // lspe_engine_tb

// [sim/lspe_video_src.sv]
// Video timing source model: frame sync and line clock
`timescale 1ns/1ns
module lspe_video_src (
    input  wire logic       pclk,
    input  wire logic       run,
    input  wire logic [7:0] line_len,
    input  wire logic [7:0] lines,
    output logic            frame_sync = 1'b0,
    output logic            line_clk = 1'b0
);
    int cyc = 0;
    // Line clock stands low while stopped
    always @(posedge pclk) begin
        cyc <= (!run || cyc >= line_len * lines - 1) ? 0 : cyc + 1;
        frame_sync <= run && cyc == 0;
        line_clk <= run && cyc >= line_len && (cyc % line_len) < line_len / 2;
    end
endmodule // lspe_video_src
